// ---- adsp_map.vh ----
`ifndef ADSP_MAP_VH
`define ADSP_MAP_VH
`define ADSP_OFF_PIN0      6'h00
`define ADSP_OFF_PIN7      6'h1c
`define ADSP_OFF_GEN       6'h20
`define ADSP_OFF_IRQ_STAT  6'h24
`define ADSP_OFF_IRQ_MASK  6'h28
`define ADSP_GEN_DROP_BIT  24
`define ADSP_GEN_WID_HI    17
`define ADSP_GEN_WID_LO    16
`define ADSP_GEN_LEN_HI    15
`define ADSP_GEN_LEN_LO    8
`define ADSP_GEN_CAL_BIT   1
`define ADSP_GEN_EN_BIT    0
`define ADSP_PIN_DEST_HI   31
`define ADSP_PIN_DEST_LO   8
`define ADSP_PIN_EN_BIT    0
`define ADSP_WID_8         2'h0
`define ADSP_WID_16        2'h1
`define ADSP_WID_32        2'h3
`define ADSP_RST_WID       2'h1
`define ADSP_RST_LEN       8'h01
`define ADSP_RST_DROP      1'b1
`define ADSP_CAL_PULSES    3'h6
`define ADSP_IRQ_DROP_BIT  0
`define ADSP_IRQ_PKT_BIT   1
`endif

// ---- adsp_formatter.v ----
`timescale 1ns/100ps
`include "adsp_map.vh"
// builds one 32-bit left-aligned word and its byte count from a 12-bit sample
module adsp_formatter (
	input  wire [11:0] i_sample,
	input  wire [1:0]  i_width,
	output reg  [31:0] o_word,
	output reg  [2:0]  o_bytes
);
	always @* begin
		case (i_width)
		`ADSP_WID_8: begin
			o_word  = {i_sample[11:4], 24'h000000};
			o_bytes = 3'h1;
		end
		`ADSP_WID_16: begin
			o_word  = {i_sample, 4'h0, 16'h0000};
			o_bytes = 3'h2;
		end
		`ADSP_WID_32: begin
			o_word  = {i_sample, 20'h00000};
			o_bytes = 3'h4;
		end
		default: begin
			o_word  = {i_sample, 4'h0, 16'h0000};
			o_bytes = 3'h2;
		end
		endcase
	end
endmodule

// ---- adsp_control.v ----
`timescale 1ns/100ps
`include "adsp_map.vh"
// Behaviour
// - pin register bits 31:8 hold destination endpoint id, reset zero
// - pin register bit 0 enables that pin for sampling, reset zero
// - general bit 24 flags dropped sample, cleared by reading it
// - width code 0:8, 1:16, 3:32 bits left aligned; code 2 reserved
// - multi-byte samples are sent most significant byte first
// - samples per packet field; zero keeps packet open until register access
// - calibration bit selects internal reference instead of pin, reset zero
// - general bit 0 enables converter; pin registers then ignore writes
// - first six pulses after enable calibrate and send nothing
// - eight pin registers at word offsets 0x00 to 0x1c
module adsp_control (
	input  wire        i_clock,
	input  wire        i_reset,
	input  wire [5:0]  i_address,
	input  wire        i_read,
	input  wire        i_write,
	input  wire [31:0] i_writedata,
	input  wire [3:0]  i_byteenable,
	output reg  [31:0] o_readdata,
	output reg         o_waitrequest,
	input  wire        i_sample_pulse,
	input  wire [11:0] i_conv_data,
	input  wire        i_conv_done,
	output reg  [2:0]  o_conv_select,
	output reg         o_conv_cal,
	output reg         o_conv_start,
	input  wire        i_tx_ready,
	output reg         o_tx_valid,
	output reg  [7:0]  o_tx_data,
	output reg  [23:0] o_tx_dest,
	output reg         o_tx_end,
	output reg         o_irq
);
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam ST_SEND = 2'h3;
	reg [23:0] dest_reg [0:7];
	reg [7:0]  pin_en_reg;
	reg        en_reg;
	reg        cal_reg;
	reg [1:0]  wid_reg;
	reg [7:0]  len_reg;
	reg        drop_reg;
	reg [1:0]  stat_reg;
	reg [1:0]  mask_reg;
	reg [2:0]  calcnt_reg;
	reg [1:0]  state_reg;
	reg [2:0]  pin_reg;
	reg [31:0] word_reg;
	reg [2:0]  left_reg;
	reg        term_reg;
	reg [7:0]  cnt_reg [0:7];
	reg [7:0]  open_reg;
	reg        acc_done_reg;
	wire [31:0] fmt_word;
	wire [2:0]  fmt_bytes;
	wire        access;
	wire        pin_hit;
	wire        drop_ev;
	wire        pkt_ev;
	wire [31:0] wmask;
	wire [7:0]  next_cnt;
	integer     k;
	integer     m;
	function [2:0] next_pin;
		input [7:0] en;
		input [2:0] from;
		input       incl;
		integer     j;
		reg [3:0]   p;
		reg         f;
		begin
			next_pin = 3'h0;
			f = 1'b0;
			for (j = 0; j < 8; j = j + 1) begin
				p = {1'b0, from} + (incl ? 4'h0 : 4'h1) + j[3:0];
				if (!f && en[p[2:0]] && (incl || p < 4'h8)) begin
					next_pin = p[2:0];
					f = 1'b1;
				end
			end
		end
	endfunction
	function any_after;
		input [7:0] en;
		input [2:0] from;
		integer     j;
		begin
			any_after = 1'b0;
			for (j = 0; j < 8; j = j + 1)
				if (j > from && en[j])
					any_after = 1'b1;
		end
	endfunction
	adsp_formatter u_fmt (
		.i_sample (i_conv_data),
		.i_width  (wid_reg),
		.o_word   (fmt_word),
		.o_bytes  (fmt_bytes)
	);
	assign wmask   = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
		{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	assign access  = (i_read | i_write) & o_waitrequest & ~acc_done_reg;
	assign pin_hit = (i_address[5] == 1'b0) && (i_address[1:0] == 2'h0);
	assign drop_ev = i_sample_pulse && en_reg && (calcnt_reg == `ADSP_CAL_PULSES)
		&& (state_reg != ST_IDLE) && (pin_en_reg != 8'h00);
	assign pkt_ev  = o_tx_valid && i_tx_ready && o_tx_end;
	assign next_cnt = cnt_reg[pin_reg] + 8'h01;
	////////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, answer on the second cycle
	always @(posedge i_clock) begin
		if (i_reset) begin
			o_waitrequest <= 1'b1;
			acc_done_reg  <= 1'b0;
			o_readdata    <= 32'h00000000;
		end else begin
			acc_done_reg  <= 1'b0;
			o_waitrequest <= 1'b1;
			if (access) begin
				o_waitrequest <= 1'b0;
				acc_done_reg  <= 1'b1;
				o_readdata    <= 32'h00000000;
				if (i_read) begin
					if (pin_hit)
						o_readdata <= {dest_reg[i_address[4:2]], 7'h00,
							pin_en_reg[i_address[4:2]]};
					else if (i_address == `ADSP_OFF_GEN)
						o_readdata <= {7'h00, drop_reg, 6'h00, wid_reg, len_reg,
							6'h00, cal_reg, en_reg};
					else if (i_address == `ADSP_OFF_IRQ_STAT)
						o_readdata <= {30'h00000000, stat_reg};
					else if (i_address == `ADSP_OFF_IRQ_MASK)
						o_readdata <= {30'h00000000, mask_reg};
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// registers
	always @(posedge i_clock) begin
		if (i_reset) begin
			for (k = 0; k < 8; k = k + 1)
				dest_reg[k] <= 24'h000000;
			pin_en_reg <= 8'h00;
			en_reg     <= 1'b0;
			cal_reg    <= 1'b0;
			wid_reg    <= `ADSP_RST_WID;
			len_reg    <= `ADSP_RST_LEN;
			drop_reg   <= `ADSP_RST_DROP;
			stat_reg   <= 2'h0;
			mask_reg   <= 2'h0;
			o_irq      <= 1'b0;
		end else begin
			if (access && i_write && pin_hit && !en_reg) begin
				dest_reg[i_address[4:2]] <= (dest_reg[i_address[4:2]] & ~wmask[31:8])
					| (i_writedata[31:8] & wmask[31:8]);
				if (i_byteenable[0])
					pin_en_reg[i_address[4:2]] <= i_writedata[`ADSP_PIN_EN_BIT];
			end
			if (access && i_write && i_address == `ADSP_OFF_GEN) begin
				if (i_byteenable[0]) begin
					en_reg  <= i_writedata[`ADSP_GEN_EN_BIT];
					cal_reg <= i_writedata[`ADSP_GEN_CAL_BIT];
				end
				if (i_byteenable[1])
					len_reg <= i_writedata[`ADSP_GEN_LEN_HI:`ADSP_GEN_LEN_LO];
				if (i_byteenable[2])
					wid_reg <= i_writedata[`ADSP_GEN_WID_HI:`ADSP_GEN_WID_LO];
			end
			if (drop_ev)
				drop_reg <= 1'b1;
			else if (access && i_read && i_address == `ADSP_OFF_GEN)
				drop_reg <= 1'b0;
			if (access && i_write && i_address == `ADSP_OFF_IRQ_MASK && i_byteenable[0])
				mask_reg <= i_writedata[1:0];
			stat_reg[`ADSP_IRQ_DROP_BIT] <= drop_ev | (stat_reg[`ADSP_IRQ_DROP_BIT] &
				~(access && i_write && i_address == `ADSP_OFF_IRQ_STAT && i_writedata[0]));
			stat_reg[`ADSP_IRQ_PKT_BIT] <= pkt_ev | (stat_reg[`ADSP_IRQ_PKT_BIT] &
				~(access && i_write && i_address == `ADSP_OFF_IRQ_STAT && i_writedata[1]));
			o_irq <= |(stat_reg & mask_reg);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// sampling and packet sequencer
	always @(posedge i_clock) begin
		if (i_reset) begin
			calcnt_reg    <= 3'h0;
			state_reg     <= ST_IDLE;
			pin_reg       <= 3'h0;
			word_reg      <= 32'h00000000;
			left_reg      <= 3'h0;
			term_reg      <= 1'b0;
			open_reg      <= 8'h00;
			for (m = 0; m < 8; m = m + 1)
				cnt_reg[m] <= 8'h00;
			o_conv_select <= 3'h0;
			o_conv_cal    <= 1'b0;
			o_conv_start  <= 1'b0;
			o_tx_valid    <= 1'b0;
			o_tx_data     <= 8'h00;
			o_tx_dest     <= 24'h000000;
			o_tx_end      <= 1'b0;
		end else begin
			o_conv_start <= 1'b0;
			o_conv_cal   <= cal_reg;
			if (!en_reg)
				calcnt_reg <= 3'h0;
			else if (i_sample_pulse && calcnt_reg != `ADSP_CAL_PULSES)
				calcnt_reg <= calcnt_reg + 3'h1;
			if (access && len_reg == 8'h00)
				open_reg <= open_reg | pin_en_reg;
			case (state_reg)
			ST_IDLE: begin
				if (i_sample_pulse && en_reg && calcnt_reg == `ADSP_CAL_PULSES
					&& pin_en_reg != 8'h00) begin
					pin_reg       <= next_pin(pin_en_reg, 3'h0, 1'b1);
					o_conv_select <= next_pin(pin_en_reg, 3'h0, 1'b1);
					o_conv_start  <= 1'b1;
					state_reg     <= ST_WAIT;
				end
			end
			ST_CONV: begin
				o_conv_select <= pin_reg;
				o_conv_start  <= 1'b1;
				state_reg     <= ST_WAIT;
			end
			ST_WAIT: begin
				if (i_conv_done) begin
					word_reg  <= fmt_word;
					left_reg  <= fmt_bytes;
					if (len_reg == 8'h00) begin
						term_reg <= open_reg[pin_reg];
						open_reg[pin_reg] <= 1'b0;
						cnt_reg[pin_reg]  <= 8'h00;
					end else if (next_cnt >= len_reg) begin
						term_reg <= 1'b1;
						cnt_reg[pin_reg] <= 8'h00;
					end else begin
						term_reg <= 1'b0;
						cnt_reg[pin_reg] <= next_cnt;
					end
					state_reg <= ST_SEND;
				end
			end
			ST_SEND: begin
				if (!o_tx_valid || i_tx_ready) begin
					if (left_reg != 3'h0) begin
						o_tx_valid <= 1'b1;
						o_tx_data  <= word_reg[31:24];
						o_tx_dest  <= dest_reg[pin_reg];
						o_tx_end   <= term_reg && left_reg == 3'h1;
						word_reg   <= {word_reg[23:0], 8'h00};
						left_reg   <= left_reg - 3'h1;
					end else begin
						o_tx_valid <= 1'b0;
						o_tx_end   <= 1'b0;
						if (any_after(pin_en_reg, pin_reg)) begin
							pin_reg   <= next_pin(pin_en_reg, pin_reg, 1'b0);
							state_reg <= ST_CONV;
						end else
							state_reg <= ST_IDLE;
					end
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// ---- adsp_control_properties.sv ----
`timescale 1ns/100ps
// bus answer, stream hold and reserved-field checks at the ports
module adsp_control_properties (
	input wire        i_clock,
	input wire        i_reset,
	input wire [5:0]  i_address,
	input wire        i_read,
	input wire        i_write,
	input wire [31:0] o_readdata,
	input wire        o_waitrequest,
	input wire        i_tx_ready,
	input wire        o_tx_valid,
	input wire [7:0]  o_tx_data,
	input wire [23:0] o_tx_dest,
	input wire        o_tx_end
);
default clocking @(posedge i_clock); endclocking
default disable iff (i_reset);
sequence s_req;
	(i_read || i_write) && o_waitrequest && $past(o_waitrequest);
endsequence
sequence s_rd;
	!o_waitrequest && i_read;
endsequence
sequence s_hold;
	o_tx_valid && !i_tx_ready;
endsequence
property p_ack; s_req |=> !o_waitrequest; endproperty
property p_one; !o_waitrequest |=> o_waitrequest; endproperty
property p_idle; !(i_read || i_write) ##1 !(i_read || i_write) |-> o_waitrequest; endproperty
property p_hold;
	s_hold |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_dest) && $stable(o_tx_end);
endproperty
property p_end; o_tx_end |-> o_tx_valid; endproperty
property p_unm; s_rd ##0 (i_address > 6'h2b) |-> o_readdata == 32'h0; endproperty
property p_pin; s_rd ##0 (i_address < 6'h20) |-> o_readdata[7:1] == 7'h0; endproperty
property p_gen;
	s_rd ##0 (i_address == 6'h20) |->
		o_readdata[31:25] == 7'h0 && o_readdata[23:18] == 6'h0 && o_readdata[7:2] == 6'h0;
endproperty
a_ack: assert property (p_ack) else $error("no answer one cycle after request");
a_one: assert property (p_one) else $error("waitrequest low too long");
a_idle: assert property (p_idle) else $error("answer without request");
a_hold: assert property (p_hold) else $error("stream byte changed while stalled");
a_end: assert property (p_end) else $error("packet end without valid");
a_unm: assert property (p_unm) else $error("unmapped read not zero");
a_pin: assert property (p_pin) else $error("pin reserved bits not zero");
a_gen: assert property (p_gen) else $error("general reserved bits not zero");
endmodule
bind adsp_control adsp_control_properties u_props (.*);

// ---- adsp_endpoint.sv ----
`timescale 1ns/100ps
// converter answering starts, and sink endpoint with optional stalling
module adsp_endpoint (
	input  wire        i_clock,
	input  wire        i_reset,
	input  wire        i_slow,
	input  wire        i_start,
	input  wire [2:0]  i_select,
	input  wire        i_cal,
	output reg         o_done = 1'b0,
	output wire [11:0] o_data,
	output reg         o_ready = 1'b0
);
reg [1:0]  dly_reg = 2'h0;
reg        busy_reg = 1'b0;
reg [11:0] val_reg = 12'h0;
// result only valid with done, inverse otherwise
assign o_data = o_done ? val_reg : ~val_reg;
always @(posedge i_clock) begin
	o_done <= 1'b0;
	o_ready <= !i_slow || !o_ready;
	if (i_reset) begin
		busy_reg <= 1'b0;
		o_ready <= 1'b0;
	end else if (i_start) begin
		busy_reg <= 1'b1;
		dly_reg <= 2'h2;
		val_reg <= {i_select, i_cal, 8'ha5};
	end else if (busy_reg) begin
		dly_reg <= dly_reg - 2'h1;
		if (dly_reg == 2'h0) begin
			busy_reg <= 1'b0;
			o_done <= 1'b1;
		end
	end
end
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
reg         i_clock = 0, i_reset = 1, i_read = 0, i_write = 0, i_sample_pulse = 0;
reg         slow = 0, cal = 0;
reg  [5:0]  i_address = 0;
reg  [31:0] i_writedata = 0, rnd = 32'hc3f9, q;
reg  [3:0]  i_byteenable = 0;
wire [31:0] o_readdata;
wire        o_waitrequest, i_conv_done, o_conv_cal, o_conv_start, i_tx_ready;
wire        o_tx_valid, o_tx_end, o_irq;
wire [11:0] i_conv_data;
wire [2:0]  o_conv_select;
wire [7:0]  o_tx_data;
wire [23:0] o_tx_dest;
integer     fails = 0, checked = 0, cyc = 0, p, w, b, n, cnt[0:7], len_v = 1;
reg  [7:0]  opn = 8'h00;
reg  [23:0] dest[0:7];
reg  [7:0]  en = 8'h84;
reg  [32:0] exp_q[$];
adsp_control i_dut (.*);
adsp_endpoint i_ep (.i_clock(i_clock), .i_reset(i_reset), .i_slow(slow),
	.i_start(o_conv_start), .i_select(o_conv_select), .i_cal(o_conv_cal),
	.o_done(i_conv_done), .o_data(i_conv_data), .o_ready(i_tx_ready));
initial forever #50 i_clock = ~i_clock;
////////////////////////////////////////////////////////////////
function [31:0] lfsr(input [31:0] s);
	lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task results;
	begin
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
endtask
task chk(input [32:0] g, input [32:0] e);
	begin
		checked = checked + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	end
endtask
task bus(input wr, input [5:0] a, input [31:0] d, output [31:0] r);
	integer k;
	begin
		@(posedge i_clock);
		i_read <= !wr;
		i_write <= wr;
		i_address <= a;
		i_writedata <= d;
		i_byteenable <= 4'hf;
		k = 0;
		do begin
			@(posedge i_clock);
			k = k + 1;
		end while (o_waitrequest !== 1'b0 && k < 50);
		r = o_readdata;
		i_read <= 0;
		i_write <= 0;
		if (len_v == 0)
			opn = opn | en;
		if (k == 50) chk(1, 0);
	end
endtask
// queue expected bytes of enabled pins, then fire one sample pulse
task pulse(input g);
	reg [11:0] s;
	reg [31:0] wd;
	integer nb;
	reg e;
	begin
		for (p = 0; p < 8; p = p + 1) if (g && en[p]) begin
			s = {p[2:0], cal, 8'ha5};
			wd = w == 0 ? {s[11:4], 24'h0} : w == 3 ? {s, 20'h0} : {s, 20'h0};
			nb = w == 0 ? 1 : w == 3 ? 4 : 2;
			cnt[p] = cnt[p] + 1;
			e = len_v == 0 ? opn[p] : cnt[p] >= len_v;
			if (e || len_v == 0)
				cnt[p] = 0;
			if (len_v == 0)
				opn[p] = 1'b0;
			for (b = 0; b < nb; b = b + 1)
				exp_q.push_back({b == nb - 1 && e, dest[p], wd[31 - 8 * b -: 8]});
		end
		@(posedge i_clock);
		i_sample_pulse <= 1;
		@(posedge i_clock);
		i_sample_pulse <= 0;
		n = 0;
		while ((exp_q.size() > 0 || n < 20) && n < 400) begin
			@(posedge i_clock);
			n = n + 1;
		end
	end
endtask
always @(posedge i_clock) begin
	cyc = cyc + 1;
	if (o_tx_valid && i_tx_ready) begin
		if (exp_q.size() == 0) chk(1, 0);
		else chk({o_tx_end, o_tx_dest, o_tx_data}, exp_q.pop_front());
	end
	if (cyc == 20000) begin
		fails = fails + 1;
		$display("Error %0t: timeout", $time);
		results;
	end
end
initial begin
	repeat (3) @(posedge i_clock);
	i_reset <= 0;
	for (p = 0; p < 8; p = p + 1)
		cnt[p] = 0;
	bus(0, 6'h20, 0, q);
	chk(q, 32'h01010100);
	bus(0, 6'h20, 0, q);
	chk(q, 32'h00010100);
	for (p = 0; p < 8; p = p + 1) begin
		bus(0, {p[3:0], 2'h0}, 0, q);
		chk(q, 0);
		rnd = lfsr(rnd);
		dest[p] = rnd[23:0];
		bus(1, {p[3:0], 2'h0}, {rnd[23:0], 7'h7f, en[p]}, q);
		bus(0, {p[3:0], 2'h0}, 0, q);
		chk(q, {dest[p], 7'h0, en[p]});
	end
	bus(0, 6'h30, 0, q);
	chk(q, 0);
	bus(1, 6'h28, 1, q);
	w = 1;
	len_v = 2;
	bus(1, 6'h20, 32'h00010201, q);
	bus(1, 6'h08, 0, q);
	bus(0, 6'h08, 0, q);
	chk(q, {dest[2], 8'h01});
	repeat (6) pulse(0);
	for (w = 0; w < 4; w = w + 1) begin
		cal = w[0];
		slow = w[1];
		bus(1, 6'h20, {14'h0, w[1:0], 8'h02, 6'h0, cal, 1'b1}, q);
		pulse(1);
		pulse(1);
	end
	w = 3;
	fork
		pulse(1);
		begin
			repeat (3) @(posedge i_clock);
			i_sample_pulse <= 1;
			@(posedge i_clock);
			i_sample_pulse <= 0;
		end
	join
	chk(o_irq, 1);
	bus(0, 6'h20, 0, q);
	chk(q[24], 1);
	bus(1, 6'h24, 1, q);
	repeat (2) @(posedge i_clock);
	chk(o_irq, 0);
	// open packets: only a register access closes them
	cal = 0;
	w = 1;
	bus(1, 6'h20, 32'h00010001, q);
	len_v = 0;
	pulse(1);
	bus(0, 6'h24, 0, q);
	chk(q, 32'h00000002);
	pulse(1);
	results;
end
endmodule
